/* File: rtl/fsp_defs.vh */
// Register map, field positions, commands and timing for the flash sequencer.
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// Register byte offsets on the control bus.
`define FSP_REG_CTRL 8'h00
`define FSP_REG_PTR 8'h04
`define FSP_REG_DATA 8'h08
`define FSP_REG_STORE 8'h0C
`define FSP_REG_LOAD 8'h10
`define FSP_REG_LDATA 8'h14
`define FSP_REG_STATUS 8'h18

// Control and status register fields.
`define FSP_CMD_MSB 4
`define FSP_BIT_EN 0
`define FSP_BIT_BUSY 6
`define FSP_BIT_IE 7

// Command patterns in the low five control bits.
`define FSP_CMD_NONE 5'h00
`define FSP_CMD_LOAD 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_REEN 5'h11

// Operation codes shown to the flash array.
`define FSP_OP_NONE 2'h0
`define FSP_OP_ERASE 2'h1
`define FSP_OP_WRITE 2'h2
`define FSP_OP_LOCK 2'h3

// Status register fields.
`define FSP_ST_FUSE 8
`define FSP_ST_STALL 9
`define FSP_ST_EE 10
`define FSP_ST_RUN 11

// Reset values and the pad above the lock bits.
`define FSP_PTR_RST 16'h0000
`define FSP_LOCK_RST 6'h3F
`define FSP_APP_RESET_ADDR 16'h0000
`define FSP_BUF_ERASED 16'hFFFF
`define FSP_LOCK_PAD 2'h3

// Timed sequence windows in clock cycles.
`define FSP_STORE_WINDOW 3'h4
`define FSP_LOAD_WINDOW 3'h3

// AXI responses.
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

// Timing: clock period, time base tick and programming time in ns.
`define FSP_CLK_NS 100
`define FSP_TICK_NS 1000
`define FSP_PROG_MIN_NS 3700000
`define FSP_TICK_DIV (`FSP_TICK_NS / `FSP_CLK_NS)
`define FSP_PROG_TICKS \
    ((`FSP_PROG_MIN_NS + `FSP_TICK_NS - 1) / `FSP_TICK_NS)

`endif

/* File: rtl/fsp_tick_div.v */
// Divider that makes the one-cycle time base tick for flash timing.
`timescale 1ns/1ns
`include "fsp_defs.vh"

module fsp_tick_div #(
    parameter integer DIV = `FSP_TICK_DIV
) (
    input wire aclk,
    input wire aresetn,
    output reg tick_ff
);
    reg [31:0] cnt_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff == DIV - 1) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end
endmodule

/* File: rtl/fsp_page_buf.v */
// Temporary page buffer with a write-once mask per word.
`timescale 1ns/1ns
`include "fsp_defs.vh"

module fsp_page_buf #(
    parameter integer IDX_W = 6,
    parameter integer DW = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire clr,
    input wire wr_en,
    input wire [IDX_W-1:0] wr_idx,
    input wire [DW-1:0] wr_data,
    input wire [IDX_W-1:0] rd_idx,
    output reg [DW-1:0] rd_data_ff,
    output wire any_loaded
);
    localparam integer WORDS = 1 << IDX_W;
    reg [DW-1:0] mem_ff [0:WORDS-1];
    reg [WORDS-1:0] used_ff;
    integer i;

    assign any_loaded = |used_ff;

    // A word already loaded keeps its first value until the buffer clears.
    always @(posedge aclk) begin
        if (!aresetn || clr) begin
            used_ff <= {WORDS{1'b0}};
            for (i = 0; i < WORDS; i = i + 1) begin
                mem_ff[i] <= `FSP_BUF_ERASED;
            end
        end else if (wr_en && !used_ff[wr_idx]) begin
            used_ff[wr_idx] <= 1'b1;
            mem_ff[wr_idx] <= wr_data;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_data_ff <= `FSP_BUF_ERASED;
        end else begin
            rd_data_ff <= mem_ff[rd_idx];
        end
    end
endmodule

/* File: rtl/fsp_selfprog.v */
// Flash self-programming sequencer with an AXI4-Lite register port.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "fsp_defs.vh"

// What this block does
// - Fuse picks application or boot reset vector.
// - Software cannot change the fuse.
// - Pointer gives page and word.
// - Page and data latch at start.
// - Lock programming ignores the pointer.
// - Pointer bit zero picks the load byte.
// - Command 0x03 and timely store erase a page.
// - Halting-area operations stall the core.
// - Command 0x01 and timely store load a word.
// - Buffer clears on write end, re-enable, reset.
// - EEPROM write during loading empties buffer.
// - Command 0x05 and timely store write a page.
// - Interrupt stands while enabled and idle.
// - Erase or write sets the busy flag.
// - Re-enable write clears the busy flag.
// - Command 0x09 programs zero lock bits.
// - EEPROM write refuses programming.
// - Armed command clears if nothing follows.
// - Operations last 3.699 to 3.7 ms.
module fsp_selfprog #(
    parameter integer IDX_W = 6,
    parameter [31:0] HALTING_AREA_FIRST_PAGE = 32'h0000_01C0,
    parameter [15:0] BOOT_RESET_ADDR = 16'h7000,
    parameter integer TICK_DIV = `FSP_TICK_DIV,
    parameter integer PROG_TICKS = `FSP_PROG_TICKS
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire boot_vector_fuse,
    input wire eeprom_write_active_flag,
    output reg [15:0] reset_vector_ff,
    output reg core_stall_ff,
    output wire area_busy_flag,
    output wire selfprog_irq,
    output reg [1:0] flash_op_ff,
    output reg [14-IDX_W:0] flash_page_ff,
    output reg [5:0] lock_bits_ff,
    input wire [IDX_W-1:0] pbuf_rd_idx,
    output wire [15:0] pbuf_rd_data,
    output reg [14:0] flash_rd_addr_ff,
    input wire [15:0] flash_rd_data
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_RUN = 2'b01;
    localparam integer PAGE_W = 15 - IDX_W;

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    reg fuse_s1_ff, fuse_s2_ff, ie_ff, busy_ff, load_pend_ff, load_hi_ff;
    reg aw_got_ff, w_got_ff, nxt_rbad;
    reg [1:0] state_ff;
    reg [2:0] arm_cnt_ff, arm_age_ff;
    reg [3:0] wstrb_ff;
    reg [4:0] cmd_ff;
    reg [5:0] lock_data_ff;
    reg [7:0] load_data_ff, aw_addr_ff;
    reg [15:0] ptr_ff, data_ff;
    reg [31:0] prog_cnt_ff, wdata_ff, nxt_rdata;
    wire tick, pbuf_any, wr_fire, wr_bad, ctrl_wr, store_wr, load_wr;
    wire armed, store_ok, pbuf_wr, prog_done, pbuf_clr, reen_ok;
    wire [PAGE_W-1:0] ptr_page;
    wire [IDX_W-1:0] ptr_word;

    ////////////////////////////////////////////////////////////////////////
    // Boot vector fuse and reset vector.
    // An outside pin, synchronised; no register write reaches it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            fuse_s1_ff <= 1'b1;
            fuse_s2_ff <= 1'b1;
            reset_vector_ff <= `FSP_APP_RESET_ADDR;
        end else begin
            fuse_s1_ff <= boot_vector_fuse;
            fuse_s2_ff <= fuse_s1_ff;
            reset_vector_ff <= fuse_s2_ff ? `FSP_APP_RESET_ADDR
                : BOOT_RESET_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers.
    fsp_tick_div #(
        .DIV(TICK_DIV)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_ff(tick)
    );

    // Page field sits above the word field; bit zero is the byte select.
    assign ptr_page = ptr_ff[15:IDX_W+1];
    assign ptr_word = ptr_ff[IDX_W:1];

    assign armed = (arm_cnt_ff != 3'h0) && cmd_ff[`FSP_BIT_EN];
    assign store_ok = store_wr && armed && (state_ff == ST_IDLE)
        && !eeprom_write_active_flag;
    assign pbuf_wr = store_ok && (cmd_ff == `FSP_CMD_LOAD);
    assign prog_done = (state_ff == ST_RUN) && tick
        && (prog_cnt_ff == PROG_TICKS - 1);
    assign reen_ok = ctrl_wr && wstrb_ff[0] && !eeprom_write_active_flag
        && (state_ff == ST_IDLE)
        && (wdata_ff[`FSP_CMD_MSB:0] == `FSP_CMD_REEN);
    // An EEPROM write throws away a partly loaded buffer.
    assign pbuf_clr = (prog_done && (flash_op_ff == `FSP_OP_WRITE))
        || reen_ok || (eeprom_write_active_flag && pbuf_any);

    fsp_page_buf #(
        .IDX_W(IDX_W),
        .DW(16)
    ) u_pbuf (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(pbuf_clr),
        .wr_en(pbuf_wr),
        .wr_idx(ptr_word),
        .wr_data(data_ff),
        .rd_idx(pbuf_rd_idx),
        .rd_data_ff(pbuf_rd_data),
        .any_loaded(pbuf_any)
    );

    assign area_busy_flag = busy_ff;
    assign selfprog_irq = ie_ff && !cmd_ff[`FSP_BIT_EN];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order.
    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign wr_bad = (aw_addr_ff != `FSP_REG_CTRL)
        && (aw_addr_ff != `FSP_REG_PTR) && (aw_addr_ff != `FSP_REG_DATA)
        && (aw_addr_ff != `FSP_REG_STORE) && (aw_addr_ff != `FSP_REG_LOAD);
    assign ctrl_wr = wr_fire && (aw_addr_ff == `FSP_REG_CTRL);
    assign store_wr = wr_fire && (aw_addr_ff == `FSP_REG_STORE);
    assign load_wr = wr_fire && (aw_addr_ff == `FSP_REG_LOAD);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FSP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_bad ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ptr_ff <= `FSP_PTR_RST;
            data_ff <= `FSP_PTR_RST;
        end else if (wr_fire) begin
            if (aw_addr_ff == `FSP_REG_PTR) begin
                if (wstrb_ff[0]) ptr_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) ptr_ff[15:8] <= wdata_ff[15:8];
            end
            if (aw_addr_ff == `FSP_REG_DATA) begin
                if (wstrb_ff[0]) data_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) data_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_rbad = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `FSP_REG_CTRL: begin
                nxt_rdata[`FSP_CMD_MSB:0] = cmd_ff;
                nxt_rdata[`FSP_BIT_BUSY] = busy_ff;
                nxt_rdata[`FSP_BIT_IE] = ie_ff;
            end
            `FSP_REG_PTR: nxt_rdata[15:0] = ptr_ff;
            `FSP_REG_DATA: nxt_rdata[15:0] = data_ff;
            `FSP_REG_STORE, `FSP_REG_LOAD: nxt_rdata = 32'h0000_0000;
            `FSP_REG_LDATA: nxt_rdata[7:0] = load_data_ff;
            `FSP_REG_STATUS: begin
                nxt_rdata[5:0] = lock_bits_ff;
                nxt_rdata[`FSP_ST_FUSE] = fuse_s2_ff;
                nxt_rdata[`FSP_ST_STALL] = core_stall_ff;
                nxt_rdata[`FSP_ST_EE] = eeprom_write_active_flag;
                nxt_rdata[`FSP_ST_RUN] = (state_ff == ST_RUN);
            end
            default: nxt_rbad = 1'b1;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rbad ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load-program reads.
    // The word address goes out one cycle, the byte is picked the next.
    // A load soon after arming the lock command returns the lock bits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            load_pend_ff <= 1'b0;
            load_hi_ff <= 1'b0;
            load_data_ff <= 8'h00;
            flash_rd_addr_ff <= 15'h0000;
        end else begin
            load_pend_ff <= 1'b0;
            if (load_pend_ff) begin
                load_data_ff <= load_hi_ff ? flash_rd_data[15:8]
                    : flash_rd_data[7:0];
            end
            if (load_wr) begin
                if (armed && (cmd_ff == `FSP_CMD_LOCK)
                        && (arm_age_ff < `FSP_LOAD_WINDOW)
                        && !eeprom_write_active_flag) begin
                    load_data_ff <= {`FSP_LOCK_PAD, lock_bits_ff};
                end else begin
                    load_pend_ff <= 1'b1;
                    load_hi_ff <= ptr_ff[0];
                    flash_rd_addr_ff <= ptr_ff[15:1];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            cmd_ff <= `FSP_CMD_NONE;
            ie_ff <= 1'b0;
            busy_ff <= 1'b0;
            arm_cnt_ff <= 3'h0;
            arm_age_ff <= 3'h0;
            core_stall_ff <= 1'b0;
            flash_op_ff <= `FSP_OP_NONE;
            flash_page_ff <= {PAGE_W{1'b0}};
            lock_data_ff <= `FSP_LOCK_RST;
            lock_bits_ff <= `FSP_LOCK_RST;
            prog_cnt_ff <= 32'h0000_0000;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (arm_cnt_ff != 3'h0) begin
                        arm_cnt_ff <= arm_cnt_ff - 3'h1;
                        arm_age_ff <= arm_age_ff + 3'h1;
                    end else begin
                        cmd_ff <= `FSP_CMD_NONE;
                    end
                    if (ctrl_wr && wstrb_ff[0]
                            && !eeprom_write_active_flag) begin
                        cmd_ff <= wdata_ff[`FSP_CMD_MSB:0];
                        ie_ff <= wdata_ff[`FSP_BIT_IE];
                        arm_age_ff <= 3'h0;
                        arm_cnt_ff <= wdata_ff[`FSP_BIT_EN]
                            ? `FSP_STORE_WINDOW : 3'h0;
                        if (reen_ok) busy_ff <= 1'b0;
                    end else if (load_wr && armed
                            && (cmd_ff == `FSP_CMD_LOCK)
                            && (arm_age_ff < `FSP_LOAD_WINDOW)) begin
                        cmd_ff <= `FSP_CMD_NONE;
                        arm_cnt_ff <= 3'h0;
                    end else if (store_ok) begin
                        arm_cnt_ff <= 3'h0;
                        prog_cnt_ff <= 32'h0000_0000;
                        case (cmd_ff)
                            `FSP_CMD_ERASE, `FSP_CMD_WRITE: begin
                                state_ff <= ST_RUN;
                                flash_op_ff <= (cmd_ff == `FSP_CMD_ERASE)
                                    ? `FSP_OP_ERASE : `FSP_OP_WRITE;
                                flash_page_ff <= ptr_page;
                                core_stall_ff <= ({{(32-PAGE_W){1'b0}},
                                    ptr_page} >= HALTING_AREA_FIRST_PAGE);
                                busy_ff <= 1'b1;
                            end
                            `FSP_CMD_LOCK: begin
                                state_ff <= ST_RUN;
                                flash_op_ff <= `FSP_OP_LOCK;
                                lock_data_ff <= data_ff[5:0];
                            end
                            default: begin
                                cmd_ff <= `FSP_CMD_NONE;
                            end
                        endcase
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        prog_cnt_ff <= prog_cnt_ff + 32'h0000_0001;
                    end
                    if (prog_done) begin
                        state_ff <= ST_IDLE;
                        cmd_ff <= `FSP_CMD_NONE;
                        core_stall_ff <= 1'b0;
                        flash_op_ff <= `FSP_OP_NONE;
                        if (flash_op_ff == `FSP_OP_LOCK) begin
                            // Programmed lock bits return to one only on reset.
                            lock_bits_ff <= lock_bits_ff
                                & lock_data_ff;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: tb/fsp_flash_model.sv */
// Flash array model answering word reads with an address pattern.
`timescale 1ns/1ns
module fsp_flash_model (
    input wire [14:0] addr,
    output wire [15:0] data
);
    // The high byte differs from the low one so that a byte swap shows.
    assign data = {addr[7:0] ^ 8'h5A, addr[7:0]};
endmodule

/* File: tb/fsp_selfprog_monitor.sv */
// Concurrent checks on the outputs of the flash sequencer.
`timescale 1ns/1ns
`include "fsp_defs.vh"
module fsp_selfprog_monitor #(
    parameter integer IDX_W = 6,
    parameter [15:0] BOOT_RESET_ADDR = 16'h7000,
    parameter integer TICK_DIV = 10,
    parameter integer PROG_TICKS = 3700
) (
    input wire aclk,
    input wire aresetn,
    input wire boot_vector_fuse,
    input wire [15:0] reset_vector_ff,
    input wire core_stall_ff,
    input wire area_busy_flag,
    input wire selfprog_irq,
    input wire [1:0] flash_op_ff,
    input wire [14-IDX_W:0] flash_page_ff,
    input wire [5:0] lock_bits_ff
);
    localparam int OP_MIN = PROG_TICKS * TICK_DIV - TICK_DIV;
    localparam int OP_MAX = PROG_TICKS * TICK_DIV + 2 * TICK_DIV;
    wire run = flash_op_ff != `FSP_OP_NONE;
    wire era_wr = flash_op_ff == `FSP_OP_ERASE;
    wire pg_wr = flash_op_ff == `FSP_OP_WRITE;
    int run_cnt_ff;
    always @(posedge aclk) begin
        if (!aresetn || !run) run_cnt_ff <= 0;
        else run_cnt_ff <= run_cnt_ff + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_op_start;
        $rose(run);
    endsequence
    sequence s_op_end;
        $fell(run);
    endsequence
    a_vec_app: assert property ((aresetn && boot_vector_fuse)[*5] |->
        reset_vector_ff == `FSP_APP_RESET_ADDR) else $error("app vector");
    a_vec_boot: assert property ((aresetn && !boot_vector_fuse)[*5] |->
        reset_vector_ff == BOOT_RESET_ADDR) else $error("boot vector");
    a_busy_in_op: assert property ((era_wr || pg_wr) |->
        area_busy_flag) else $error("busy low");
    a_stall_in_op: assert property (core_stall_ff |->
        run || $past(run)) else $error("stray stall");
    a_lock_no_stall: assert property (flash_op_ff == `FSP_OP_LOCK |->
        !core_stall_ff) else $error("lock stall");
    a_op_length: assert property (s_op_end |->
        run_cnt_ff >= OP_MIN && run_cnt_ff <= OP_MAX)
        else $error("op length");
    a_op_bound: assert property (run_cnt_ff <= OP_MAX)
        else $error("op too long");
    a_page_latched: assert property (s_op_start |=>
        $stable(flash_page_ff)[*3]) else $error("page moved");
    a_irq_quiet: assert property (run |-> !selfprog_irq)
        else $error("irq in op");
    a_lock_one_way: assert property ($changed(lock_bits_ff) |->
        (lock_bits_ff & ~$past(lock_bits_ff)) == 6'h00)
        else $error("lock bit set");
    a_busy_fall_idle: assert property ($fell(area_busy_flag) |->
        !run) else $error("busy cleared in op");
endmodule
bind fsp_selfprog fsp_selfprog_monitor #(.IDX_W(IDX_W),
    .BOOT_RESET_ADDR(BOOT_RESET_ADDR), .TICK_DIV(TICK_DIV),
    .PROG_TICKS(PROG_TICKS)) fsp_selfprog_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .boot_vector_fuse(boot_vector_fuse),
    .reset_vector_ff(reset_vector_ff), .core_stall_ff(core_stall_ff),
    .area_busy_flag(area_busy_flag), .selfprog_irq(selfprog_irq),
    .flash_op_ff(flash_op_ff), .flash_page_ff(flash_page_ff),
    .lock_bits_ff(lock_bits_ff)
);

/* File: tb/fsp_selfprog_test.sv */
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/1ns
`include "fsp_defs.vh"
module fsp_selfprog_test;
    reg aclk = 1'b0, aresetn = 1'b0, boot_vector_fuse = 1'b1;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    reg eeprom_write_active_flag = 1'b0, p_a, p_w;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0000_0000;
    reg [5:0] pbuf_rd_idx = 6'h00, lockm = 6'h3F;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, core_stall_ff, area_busy_flag, selfprog_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, flash_op_ff;
    wire [31:0] s_axi_rdata;
    wire [15:0] reset_vector_ff, pbuf_rd_data, flash_rd_data;
    wire [8:0] flash_page_ff;
    wire [5:0] lock_bits_ff;
    wire [14:0] flash_rd_addr_ff;
    integer error_cnt = 0, samples_checked = 0, seed = 30, cyc = 0, i, k;
    integer bufm [0:63];
    reg [15:0] ptr, w;
    reg [31:0] rd, dat;
    reg [1:0] rsp;
    reg [4:0] c;
    reg [8:0] pg;
    fsp_selfprog #(.TICK_DIV(2), .PROG_TICKS(8)) fsp_selfprog_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .boot_vector_fuse,
        .eeprom_write_active_flag, .reset_vector_ff, .core_stall_ff,
        .area_busy_flag, .selfprog_irq, .flash_op_ff, .flash_page_ff,
        .lock_bits_ff, .pbuf_rd_idx, .pbuf_rd_data, .flash_rd_addr_ff,
        .flash_rd_data
    );
    fsp_flash_model fsp_flash_model_i (
        .addr(flash_rd_addr_ff),
        .data(flash_rd_data)
    );
    ////////////////////////////////////////////////////////////////////////
    always #50 aclk = ~aclk;
    task summarize;
        begin
            $display("errors %0d checks %0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            p_a = 1'b1;
            p_w = 1'b1;
            while (p_a || p_w) begin
                @(negedge aclk);
                if (s_axi_awready) p_a = 1'b0;
                if (s_axi_wready) p_w = 1'b0;
                @(posedge aclk);
                if (!p_a) s_axi_awvalid <= 1'b0;
                if (!p_w) s_axi_wvalid <= 1'b0;
            end
            @(negedge aclk);
            while (!s_axi_bvalid) @(negedge aclk);
            rsp = s_axi_bresp;
            @(posedge aclk);
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(negedge aclk);
            while (!s_axi_arready) @(negedge aclk);
            @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            @(negedge aclk);
            while (!s_axi_rvalid) @(negedge aclk);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
        end
    endtask
    // Nothing may fall between control write and store.
    task spm(input [4:0] cmd);
        begin
            wr(`FSP_REG_CTRL, {27'h000_0000, cmd});
            wr(`FSP_REG_STORE, 32'h0000_0000);
        end
    endtask
    task wait_idle;
        begin
            rd_reg(`FSP_REG_CTRL);
            while (rd[0]) rd_reg(`FSP_REG_CTRL);
        end
    endtask
    task cmp_buf;
        begin
            for (i = 0; i < 64; i = i + 1) begin
                pbuf_rd_idx <= i[5:0];
                repeat (3) @(posedge aclk);
                check(pbuf_rd_data, bufm[i]);
            end
        end
    endtask
    task load8(input erase);
        begin
            for (i = 0; i < 64; i = i + 1) if (erase) bufm[i] = 'hFFFF;
            for (k = 0; k < 8; k = k + 1) begin
                i = k * 8 + ($random(seed) & 7);
                dat = $random(seed);
                bufm[i] = dat[15:0];
                wr(`FSP_REG_PTR, {16'h0000, 9'h005, i[5:0], 1'b1});
                wr(`FSP_REG_DATA, dat);
                spm(`FSP_CMD_LOAD);
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        check(reset_vector_ff, 16'h0000);
        boot_vector_fuse <= 1'b0;
        repeat (6) @(posedge aclk);
        check(reset_vector_ff, 16'h7000);
        boot_vector_fuse <= 1'b1;
        rd_reg(`FSP_REG_STATUS);
        check(rd[5:0], 6'h3F);
        wr(8'h1C, 32'h0000_0001);
        check(rsp, `FSP_RESP_SLVERR);
        rd_reg(8'h20);
        check(rsp, `FSP_RESP_SLVERR);
        load8(1'b1);
        cmp_buf;
        eeprom_write_active_flag <= 1'b1;
        spm(`FSP_CMD_ERASE);
        check(flash_op_ff, `FSP_OP_NONE);
        eeprom_write_active_flag <= 1'b0;
        load8(1'b1);
        cmp_buf;
        for (i = 0; i < 64; i = i + 1) bufm[i] = 'hFFFF;
        for (k = 0; k < 4; k = k + 1) begin
            c = k[0] ? `FSP_CMD_WRITE : `FSP_CMD_ERASE;
            pg = k[1] ? 9'h1C0 : 9'h005;
            w = k[0] ? 16'h0000 : $random(seed);
            wr(`FSP_REG_PTR, {16'h0000, pg, w[6:0]});
            spm(c);
            check(flash_op_ff, k[0] ? 2'h2 : 2'h1);
            check(core_stall_ff, k[1]);
            check(area_busy_flag, 1'b1);
            wr(`FSP_REG_PTR, $random(seed));
            check(flash_page_ff, pg);
            rd_reg(`FSP_REG_CTRL);
            check(rd[0], 1'b1);
            wait_idle;
            check(area_busy_flag, 1'b1);
            wr(`FSP_REG_CTRL, 32'h0000_0011);
            check(area_busy_flag, 1'b0);
        end
        cmp_buf;
        dat = ($random(seed) & 32'h0000_00F6) | 32'h0000_00C0;
        lockm = lockm & dat[5:0];
        wr(`FSP_REG_PTR, $random(seed));
        wr(`FSP_REG_DATA, dat);
        spm(`FSP_CMD_LOCK);
        check(flash_op_ff, `FSP_OP_LOCK);
        wait_idle;
        check(lock_bits_ff, lockm);
        wr(`FSP_REG_CTRL, 32'h0000_0003);
        repeat (5) @(posedge aclk);
        rd_reg(`FSP_REG_CTRL);
        check(rd[0], 1'b0);
        wr(`FSP_REG_STORE, 32'h0000_0000);
        check(flash_op_ff, `FSP_OP_NONE);
        wr(`FSP_REG_CTRL, 32'h0000_0081);
        check(selfprog_irq, 1'b0);
        repeat (6) @(posedge aclk);
        check(selfprog_irq, 1'b1);
        for (k = 0; k < 2; k = k + 1) begin
            ptr = ($random(seed) & 16'hFFFE) | k[0];
            wr(`FSP_REG_PTR, {16'h0000, ptr});
            wr(`FSP_REG_LOAD, 32'h0000_0000);
            rd_reg(`FSP_REG_LDATA);
            w = {ptr[8:1] ^ 8'h5A, ptr[8:1]};
            check(rd[7:0], k[0] ? w[15:8] : w[7:0]);
        end
        summarize;
    end
endmodule
